//--- rtl/ppm_regs.vh
// constants of the power-management capability block
`ifndef PPM_REGS_VH
`define PPM_REGS_VH
// ***********************************
// register dword indexes and capability field values
// ***********************************
`define PPM_OFS_CAP        2'h0
`define PPM_OFS_CSR        2'h1
`define PPM_PM_CAPABILITY_ID         8'h01
`define PPM_NEXT_PTR       8'h00
`define PPM_WAKE_STATES    5'h0C
`define PPM_LIGHT_SUP      1'h1
`define PPM_SHALLOW_SUP    1'h0
`define PPM_AUX_CUR        3'h0
`define PPM_DSI            1'h0
`define PPM_WAKE_CLK       1'h0
`define PPM_VERSION        3'h1
`define PPM_BRIDGE         8'h00
// ***********************************
// control/status field positions
// ***********************************
`define PPM_WSTAT_BIT      15
`define PPM_SCALE_HI       14
`define PPM_SCALE_LO       13
`define PPM_SEL_HI         12
`define PPM_SEL_LO         9
`define PPM_WEN_BIT        8
`define PPM_PS_HI          1
`define PPM_PS_LO          0
// ***********************************
// power states, reset values and last data select
// ***********************************
`define PPM_D0             2'h0
`define PPM_FORBID         2'h1
`define PPM_D2             2'h2
`define PPM_D3             2'h3
`define PPM_SCALE_RST      2'h0
`define PPM_SEL_RST        4'h0
`define PPM_SEL_NORMAL     4'h8
// ***********************************
// recovery timing
// ***********************************
`define PPM_CLK_MHZ        100
`define PPM_D2_REC_US      200
`define PPM_D3_REC_MS      10
`endif

//--- rtl/ppm_wake.v
// wake request latch for the power-management block
`timescale 1ns/1ns
module ppm_wake (
  // clock and reset
  input  wire ref_clk,
  input  wire rst_b,
  // conditions
  input  wire       wake_enable,
  input  wire       low_power,
  input  wire       cable_power,
  input  wire       port_connected,
  input  wire       link_event,
  input  wire       status_clear,
  // wake request
  output wire       wake_status,
  output wire       wake_req_n
);
  reg wake_ff;
  reg nxt_wake;
  wire set_ev;
  assign set_ev = wake_enable & low_power & cable_power & port_connected & link_event;
  always @* begin
    nxt_wake = wake_ff;
    if (status_clear | ~wake_enable) begin
      nxt_wake = 1'b0;
    end
    if (set_ev) begin
      nxt_wake = 1'b1; // set wins over the clear
    end
  end
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= nxt_wake;
    end
  end
  assign wake_status = wake_ff;
  assign wake_req_n  = ~wake_ff;
endmodule // ppm_wake

//--- rtl/ppm_timer.v
// recovery down-counter for power state exits
`timescale 1ns/1ns
module ppm_timer #(
  parameter W = 20
) (
  // clock and reset
  input  wire         ref_clk,
  input  wire         rst_b,
  // control
  input  wire         start,
  input  wire [W-1:0] load,
  // status
  output wire         busy
);
  reg [W-1:0] cnt_ff;
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      cnt_ff <= {W{1'b0}};
    end else if (start) begin
      cnt_ff <= load;
    end else if (cnt_ff != {W{1'b0}}) begin
      cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
    end
  end
  assign busy = (cnt_ff != {W{1'b0}});
endmodule // ppm_timer

//--- rtl/ppm_top.v
// power-management capability: registers, power state, wake and recovery
// What this block does
// - power state field selects D0, D2, D3hot
// - D2 to D0 recovers within 200 us
// - D3hot exit needs soft reset, 10 ms
// - config access answered while in D2
// - low-power link event raises wake when enabled
// - wake dropped by status write or disable
// - wake status bit 15, resets zero, W1C
// - wake enable bit 8 gates wake
// - capability identifier reads 01h
// - next pointer reads 00h
// - wake capable states read 0Ch
// - D1 reported unsupported, bit 25
// - aux current and DSI read zero
// - bit 19 says no clock needed
// - version field reads 001b
// - bridge extension byte reads 00h
// - data select 0-7 shows power/temperature
// - data select 8 shows transfer power
// - scale field sets data unit
`timescale 1ns/1ns
`include "ppm_regs.vh"
module ppm_top #(
  parameter [31:0] D2_REC_CYC = `PPM_D2_REC_US * `PPM_CLK_MHZ,
  parameter [31:0] D3_REC_CYC = `PPM_D3_REC_MS * 1000 * `PPM_CLK_MHZ,
  parameter [71:0] DATA_TABLE = 72'h0
) (
  // clock and reset; host_bus_reset_n arrives as rst_b
  input  wire        ref_clk,
  input  wire        rst_b,
  // configuration access, dword index within capability
  input  wire        cfg_rd,
  input  wire        cfg_wr,
  input  wire [1:0]  cfg_addr,
  input  wire [3:0]  cfg_be,
  input  wire [31:0] cfg_wdata,
  output reg  [31:0] cfg_rdata,
  output wire        cfg_ack,
  // host controller soft reset
  input  wire        host_ctrl_soft_reset,
  // link side
  input  wire        cable_power,
  input  wire        port_connected,
  input  wire        link_event,
  // power state outputs
  output wire [1:0]  power_state,
  output wire        recovering,
  output wire        wake_req_n
);
  // ***********************************
  // control registers
  // ***********************************
  reg  [1:0]  state_ff;
  reg  [1:0]  req_ff;
  reg  [1:0]  scale_ff;
  reg  [3:0]  sel_ff;
  reg         wen_ff;
  reg  [31:0] rdata_ff;
  reg         ack_ff;
  wire        wake_status;
  wire        rec_busy;
  wire        csr_wr;
  wire        lo_wr;
  wire        hi_wr;
  wire [1:0]  ps_wr;
  reg         rec_start;
  reg  [31:0] rec_load;
  reg  [1:0]  nxt_state;
  assign csr_wr = cfg_wr & (cfg_addr == `PPM_OFS_CSR);
  assign lo_wr  = csr_wr & cfg_be[0];
  assign hi_wr  = csr_wr & cfg_be[1];
  assign ps_wr  = cfg_wdata[`PPM_PS_HI:`PPM_PS_LO];
  // pick one byte of the readout table
  function [7:0] tbl_byte;
    input [71:0] tbl;
    input [3:0]  idx;
    begin
      tbl_byte = (idx <= `PPM_SEL_NORMAL) ? tbl[idx*8 +: 8] : 8'h00;
    end
  endfunction
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      req_ff   <= `PPM_D0;
      scale_ff <= `PPM_SCALE_RST;
      sel_ff   <= `PPM_SEL_RST;
      wen_ff   <= 1'b0; // zero chosen so no wake fires before software arms it
    end else begin
      if (lo_wr && ps_wr != `PPM_FORBID) begin
        req_ff <= ps_wr;
      end
      if (lo_wr) begin
        sel_ff[0] <= cfg_wdata[`PPM_SEL_LO];
      end
      if (hi_wr) begin
        wen_ff   <= cfg_wdata[`PPM_WEN_BIT];
        sel_ff[3:1] <= cfg_wdata[`PPM_SEL_HI:`PPM_SEL_LO+1];
        scale_ff <= cfg_wdata[`PPM_SCALE_HI:`PPM_SCALE_LO];
      end
    end
  end
  // ***********************************
  // power state sequencing
  // ***********************************
  always @* begin
    nxt_state = state_ff;
    rec_start = 1'b0;
    rec_load  = D2_REC_CYC;
    case (state_ff)
      `PPM_D0: begin
        if (!rec_busy && req_ff != `PPM_D0) begin
          nxt_state = req_ff;
        end
      end
      `PPM_D2: begin
        if (req_ff == `PPM_D0) begin
          nxt_state = `PPM_D0;
          rec_start = 1'b1;
        end else if (req_ff == `PPM_D3) begin
          nxt_state = `PPM_D3;
        end
      end
      `PPM_D3: begin
        if (host_ctrl_soft_reset && req_ff == `PPM_D0) begin
          nxt_state = `PPM_D0;
          rec_start = 1'b1;
          rec_load  = D3_REC_CYC;
        end
      end
      default: begin
        nxt_state = `PPM_D0;
      end
    endcase
  end
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      state_ff <= `PPM_D0;
    end else begin
      state_ff <= nxt_state;
    end
  end
  ppm_timer #(.W(32)) u_timer (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .start   (rec_start),
    .load    (rec_load),
    .busy    (rec_busy)
  );
  ppm_wake u_wake (
    .ref_clk        (ref_clk),
    .rst_b          (rst_b),
    .wake_enable    (wen_ff),
    .low_power      (state_ff != `PPM_D0),
    .cable_power    (cable_power),
    .port_connected (port_connected),
    .link_event     (link_event),
    .status_clear   (hi_wr & cfg_wdata[`PPM_WSTAT_BIT]),
    .wake_status    (wake_status),
    .wake_req_n     (wake_req_n)
  );
  // ***********************************
  // read path; runs in every state so D2 still answers
  // ***********************************
  always @* begin
    cfg_rdata = rdata_ff;
  end
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      rdata_ff <= 32'h0000_0000;
      ack_ff   <= 1'b0;
    end else begin
      ack_ff <= cfg_rd | cfg_wr;
      if (cfg_rd) begin
        case (cfg_addr)
          `PPM_OFS_CAP: begin
            rdata_ff <= {`PPM_WAKE_STATES, `PPM_LIGHT_SUP, `PPM_SHALLOW_SUP,
                         `PPM_AUX_CUR, `PPM_DSI, 1'b0, `PPM_WAKE_CLK,
                         `PPM_VERSION, `PPM_NEXT_PTR, `PPM_PM_CAPABILITY_ID};
          end
          `PPM_OFS_CSR: begin
            rdata_ff <= {tbl_byte(DATA_TABLE, sel_ff), `PPM_BRIDGE,
                         wake_status, scale_ff, sel_ff, wen_ff, 6'h00, state_ff};
          end
          default: begin
            rdata_ff <= 32'h0000_0000;
          end
        endcase
      end
    end
  end
  assign cfg_ack     = ack_ff;
  assign power_state = state_ff;
  assign recovering  = rec_busy;
endmodule // ppm_top

//--- dv/ppm_top_assertions.sv
// port checker for the power-management block
`timescale 1ns/1ns
module ppm_chk (
  // clock, reset and requests
  input wire        ref_clk, rst_b, cfg_rd, cfg_wr, host_ctrl_soft_reset,
  input wire [1:0]  cfg_addr,
  input wire [3:0]  cfg_be,
  input wire [31:0] cfg_wdata, cfg_rdata,
  // link side and state
  input wire        cable_power, port_connected, link_event, cfg_ack, recovering, wake_req_n,
  input wire [1:0]  power_state
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire wr1 = cfg_wr && cfg_addr == 2'h1;
  wire rd1 = cfg_rd && cfg_addr == 2'h1;
  a_ack_follows: assert property ((cfg_rd || cfg_wr) |=> cfg_ack) else $error("ack missing");
  a_ack_single: assert property (!(cfg_rd || cfg_wr) |=> !cfg_ack) else $error("stray ack");
  a_cap_word: assert property (cfg_rd && cfg_addr == 2'h0 |=> cfg_rdata == 32'h6401_0001)
    else $error("capability dword wrong");
  a_bridge_zero: assert property (rd1 |=> cfg_rdata[23:16] == 8'h00) else $error("bridge byte");
  a_forbid_keep: assert property (wr1 && cfg_be[0] && cfg_wdata[1:0] == 2'h1 |-> ##2 power_state == $past(power_state, 2))
    else $error("forbidden code moved state");
  a_d3_hold: assert property (power_state == 2'h3 && !host_ctrl_soft_reset |=> power_state == 2'h3)
    else $error("left D3 without soft reset");
  a_wake_cause: assert property ($fell(wake_req_n) |-> $past(link_event && cable_power && port_connected && power_state[1]))
    else $error("wake without cause");
  a_wake_clear: assert property (wr1 && cfg_be[1] && cfg_wdata[15] && !link_event |=> wake_req_n)
    else $error("wake not cleared");
  a_status_view: assert property (rd1 |=> cfg_rdata[15] == !$past(wake_req_n)) else $error("status bit");
  a_recover_end: assert property ($rose(recovering) |-> ##[1:200] !recovering) else $error("recovery too long");
  c_wake: cover property ($fell(wake_req_n));
  c_light: cover property (power_state == 2'h2);
  c_recover: cover property ($rose(recovering));
endmodule // ppm_chk
bind ppm_top ppm_chk ppm_chk_i (.*);

//--- dv/ppm_host.sv
// configuration software model: single-cycle config strobes
`timescale 1ns/1ns
module ppm_host (
  // bus side
  input wire        ref_clk, cfg_ack,
  input wire [31:0] cfg_rdata,
  output reg        cfg_rd, cfg_wr,
  output reg [1:0]  cfg_addr,
  output reg [3:0]  cfg_be,
  output reg [31:0] cfg_wdata
);
  initial {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = '0;
  task acc(input bit rd, input [1:0] a, input [15:0] d, output logic [31:0] q, output logic ok);
    @(posedge ref_clk);
    cfg_rd <= rd;
    cfg_wr <= !rd;
    cfg_addr <= a;
    cfg_be <= 4'h3;
    cfg_wdata <= {16'h0000, d};
    @(posedge ref_clk);
    cfg_rd <= 1'b0;
    cfg_wr <= 1'b0;
    // released data must not look valid
    cfg_wdata <= ~{16'h0000, d};
    // ack stands only until the next edge, so look while it stands
    #1 q = cfg_rdata;
    ok = cfg_ack;
  endtask
  // disable first so a late request cannot survive the status clear
  task init;
    logic [31:0] q;
    logic k;
    acc(0, 2'h1, 16'h0000, q, k);
    acc(0, 2'h1, 16'h8000, q, k);
  endtask
endmodule // ppm_host

//--- dv/testbench.sv
// self-checking bench for the power-management block
`timescale 1ns/1ns
module testbench;
  localparam [71:0] TBL = 72'h8877_6655_4433_2211_F0;
  logic ref_clk, rst_b, cfg_rd, cfg_wr, cfg_ack, host_ctrl_soft_reset, cable_power, port_connected;
  logic link_event, recovering, wake_req_n, ok;
  logic [1:0] cfg_addr, power_state;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, q;
  int err_total, checked, cyc;
  ppm_top #(.D2_REC_CYC(32'd20), .D3_REC_CYC(32'd100), .DATA_TABLE(TBL)) ppm_top_i (.*);
  ppm_host ppm_host_i (.*);
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task acc(input bit rd, input [1:0] a, input [15:0] d);
    ppm_host_i.acc(rd, a, d, q, ok);
    chk("ack", 1, ok);
  endtask
  task nxt;
    @(posedge ref_clk) #1;
  endtask
  task wait_rec(input int n);
    int k;
    for (k = 0; k < 1000 && recovering !== 1'b0; k++) nxt;
    chk("recovery bound", 1, k <= n);
  endtask
  task pulse;
    @(posedge ref_clk) link_event <= 1'b1;
    @(posedge ref_clk) link_event <= 1'b0;
    nxt;
  endtask
  task t_ids;
    acc(1, 2'h0, 0);
    chk("cap", 32'h6401_0001, q);
    acc(1, 2'h1, 0);
    chk("bridge", 0, q[23:16]);
    chk("status reset", 0, q[15]);
    acc(1, 2'h2, 0);
    chk("unmapped", 0, q);
    $display("ids done");
  endtask
  task t_data;
    for (int i = 0; i < 9; i++) begin
      acc(0, 2'h1, {1'b0, 2'(1 + i % 3), 4'(i), 9'h000});
      acc(1, 2'h1, 0);
      chk("readout", TBL[i*8 +: 8], q[31:24]);
      chk("scale", 1 + i % 3, q[14:13]);
    end
    $display("data done");
  endtask
  task go(input [15:0] d, input [1:0] e, input string n);
    acc(0, 2'h1, d);
    nxt;
    chk(n, e, power_state);
  endtask
  task t_state;
    go(16'h0002, 2'h2, "to light");
    go(16'h0001, 2'h2, "forbidden");
    go(16'h0000, 2'h0, "light exit");
    chk("recovering", 1, recovering);
    wait_rec(25);
    go(16'h0003, 2'h3, "to deep");
    go(16'h0000, 2'h3, "deep held");
    @(posedge ref_clk) host_ctrl_soft_reset <= 1'b1;
    go(16'h0000, 2'h0, "deep exit");
    wait_rec(105);
    @(posedge ref_clk) host_ctrl_soft_reset <= 1'b0;
    $display("states done");
  endtask
  task t_wake;
    ppm_host_i.init;
    go(16'h0102, 2'h2, "armed");
    pulse;
    chk("wake", 0, wake_req_n);
    acc(1, 2'h1, 0);
    chk("status", 1, q[15]);
    acc(0, 2'h1, 16'h8102);
    chk("w1c", 1, wake_req_n);
    pulse;
    chk("rewake", 0, wake_req_n);
    acc(0, 2'h1, 16'h0002);
    nxt;
    chk("disable", 1, wake_req_n);
    pulse;
    chk("gated", 1, wake_req_n);
    go(16'h0000, 2'h0, "back");
    wait_rec(25);
    $display("wake done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      final_report;
    end
  end
  initial begin
    {rst_b, host_ctrl_soft_reset, link_event} = '0;
    {cable_power, port_connected} = 2'b11;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_ids;
    t_data;
    t_state;
    t_wake;
    final_report;
  end
endmodule // testbench
